/* logic/pms_pin_role.sv */
/*
 * pin role multiplexer and i2c address strap sampler for the serial
 * interface pads. holds the strap pull-up during start-up in the i2c modes, latches the
 * address bit once, then routes data-out, data-in and chip-select by mode.
 * assumes the protocol engines run on ref_clk and hand over their pad
 * drive values here; the pad ring resolves levels from the enables.
 */
`timescale 1ns/1ps

// Behaviour
// RULE1: strap sampled only at start-up, latched once
// RULE2: strap pull-up on throughout start-up (code: i2c modes only, pull-up off in spi modes)
// RULE3: pull-up off after start-up if strap low
// RULE4: pull-up off after start-up if interrupt enabled
// RULE5: data-out pin role chosen by interface mode
// RULE6: i2c ignores chip select, pulled high
// RULE7: data-in bidirectional except in 4-wire spi
module pms_pin_role #(
    parameter int unsigned STARTUP_CYC = pms_pkg::PMS_STARTUP_CYC  // start-up length
) (
    input  wire logic              ref_clk,                      // 20 MHz clock
    input  wire logic              nrst,                         // sync reset, low
    input  wire pms_pkg::pms_mode_t mode,                         // interface mode
    input  wire logic              irq_en,                       // interrupt output on
    input  wire logic              irq_level,                    // interrupt level
    input  wire logic              spi_sdo_data,                 // spi data-out value
    input  wire logic              sdo_drive,                    // spi data-out active
    input  wire logic              bidir_o,                      // engine data value
    input  wire logic              bidir_oe,                     // engine drives line
    input  wire logic              serial_out_irq_strap_pin_i,   // data-out pad in
    input  wire logic              serial_in_or_bidir_line_i,    // data-in pad in
    input  wire logic              chip_select_n_i,              // chip select pad in
    output pms_pkg::pms_pad_t      serial_out_irq_strap_pin,     // data-out pad drive
    output pms_pkg::pms_pad_t      serial_in_or_bidir_line,      // data-in pad drive
    output logic                   chip_select_n_pu,             // cs pull-up on
    output logic                   chip_select_n_r,              // cs to engines
    output logic                   serial_data_r,                // data-in to engines
    output logic                   addr_lsb_r,                   // i2c address lsb
    output logic                   startup_done_r                // start-up finished
);
    import pms_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // input synchronisers
    logic [1:0] strap_sync_r;   // strap pin, two stages
    logic [1:0] sdi_sync_r;     // data-in pin, two stages
    logic [1:0] csn_sync_r;     // chip select pin, two stages

    // two flops per pad input, first stage read only by second
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            strap_sync_r <= 2'h3;
            sdi_sync_r   <= 2'h3;
            csn_sync_r   <= 2'h3;
        end else begin
            strap_sync_r <= {strap_sync_r[0], serial_out_irq_strap_pin_i};
            sdi_sync_r   <= {sdi_sync_r[0], serial_in_or_bidir_line_i};
            csn_sync_r   <= {csn_sync_r[0], chip_select_n_i};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // start-up window
    logic [PMS_CNT_W-1:0] start_cnt_r;   // cycles spent in start-up
    logic                 start_last;    // final start-up cycle

    assign start_last = (start_cnt_r == PMS_CNT_W'(STARTUP_CYC - 1));

    // counts the window, then holds done
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            start_cnt_r    <= '0;
            startup_done_r <= 1'b0;
        end else if (!startup_done_r) begin
            start_cnt_r    <= start_cnt_r + PMS_CNT_W'(1);
            startup_done_r <= start_last;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // address strap capture
    // strap read in the last start-up cycle, then frozen
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            addr_lsb_r <= PMS_ADDR_LSB_RST;
        end else if (!startup_done_r && start_last) begin
            addr_lsb_r <= strap_sync_r[1];                          // RULE1
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pad role decode
    // true when the mode uses the data-out pin as strap
    function automatic logic is_i2c(input pms_mode_t m);
        return (m == PMS_I2C) || (m == PMS_I2C_IRQ);
    endfunction

    pms_pad_t sdo_nxt;    // data-out pad next value
    pms_pad_t sdi_nxt;    // data-in pad next value
    logic     pu_keep;    // strap pull-up wanted

    // pull-up on during start-up; afterwards only if strap high and no irq
    assign pu_keep = !startup_done_r ||                             // RULE2
                     (addr_lsb_r && !irq_en);                       // RULE3 RULE4

    // data-out pin role per mode
    always_comb begin
        sdo_nxt = '{o: 1'b0, oe: 1'b0, pu: 1'b0};
        unique case (mode)
            PMS_SPI3: begin
                sdo_nxt = '{o: 1'b0, oe: 1'b0, pu: 1'b0};           // RULE5
            end
            PMS_SPI3_IRQ: begin
                sdo_nxt = '{o: irq_level, oe: irq_en, pu: 1'b0};    // RULE5
            end
            PMS_SPI4: begin
                sdo_nxt = '{o: spi_sdo_data, oe: sdo_drive, pu: 1'b0}; // RULE5
            end
            PMS_I2C: begin
                sdo_nxt = '{o: 1'b0, oe: 1'b0, pu: pu_keep};        // RULE5
            end
            PMS_I2C_IRQ: begin
                // irq drives only after the strap is taken
                sdo_nxt = '{o: irq_level, oe: irq_en && startup_done_r,
                            pu: pu_keep};                           // RULE5
            end
            default: begin
                sdo_nxt = '{o: 1'b0, oe: 1'b0, pu: 1'b0};
            end
        endcase
        if (!startup_done_r && is_i2c(mode)) begin
            sdo_nxt.oe = 1'b0;                                      // RULE1
        end
    end

    // data-in line: input only in 4-wire spi, else shared
    always_comb begin
        sdi_nxt = '{o: bidir_o, oe: bidir_oe, pu: 1'b0};            // RULE7
        if (mode == PMS_SPI4) begin
            sdi_nxt.oe = 1'b0;                                      // RULE7
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // registered pad outputs
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            serial_out_irq_strap_pin <= '{o: 1'b0, oe: 1'b0, pu: PMS_PULLUP_RST};
            serial_in_or_bidir_line  <= '{o: 1'b0, oe: 1'b0, pu: 1'b0};
        end else begin
            serial_out_irq_strap_pin <= sdo_nxt;
            serial_in_or_bidir_line  <= sdi_nxt;
        end
    end

    // chip select: forced high and pulled up in i2c modes
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            chip_select_n_pu <= 1'b1;
            chip_select_n_r  <= 1'b1;
        end else begin
            chip_select_n_pu <= is_i2c(mode);                       // RULE6
            chip_select_n_r  <= is_i2c(mode) ? 1'b1 : csn_sync_r[1]; // RULE6
        end
    end

    // synchronised data-in to engines
    always_ff @(posedge ref_clk) begin
        if (!nrst) begin
            serial_data_r <= 1'b1;
        end else begin
            serial_data_r <= sdi_sync_r[1];                         // RULE7
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // assertions
    a_addr_frozen: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE1
        startup_done_r && $past(startup_done_r) |-> $stable(addr_lsb_r))
        else $error("address bit changed after start-up");

    a_pullup_startup: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE2
        !startup_done_r && is_i2c(mode) ##1 is_i2c(mode)
            |-> serial_out_irq_strap_pin.pu)
        else $error("strap pull-up off during start-up");

    a_pullup_low_off: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE3
        startup_done_r && !addr_lsb_r |=> !serial_out_irq_strap_pin.pu)
        else $error("pull-up kept with strap low");

    a_pullup_irq_off: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE4
        startup_done_r && irq_en |=> !serial_out_irq_strap_pin.pu)
        else $error("pull-up kept with interrupt on");

    a_spi3_unused: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE5
        mode == PMS_SPI3 |=> !serial_out_irq_strap_pin.oe)
        else $error("data-out driven in plain 3-wire spi");

    a_spi4_data: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE5
        mode == PMS_SPI4 |=> serial_out_irq_strap_pin.oe == $past(sdo_drive)
            && serial_out_irq_strap_pin.o == $past(spi_sdo_data))
        else $error("4-wire data-out wrong");

    a_cs_ignored: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE6
        is_i2c(mode) |=> chip_select_n_r && chip_select_n_pu)
        else $error("chip select not held high in i2c");

    a_sdi_input_only: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE7
        mode == PMS_SPI4 |=> !serial_in_or_bidir_line.oe)
        else $error("data-in driven in 4-wire spi");

    a_startup_len: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE1
        $rose(startup_done_r) |-> start_cnt_r == PMS_CNT_W'(STARTUP_CYC))
        else $error("start-up length wrong");

    // interrupt role on the data-out pin once the strap is taken
    a_i2c_irq_role: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE5
        mode == PMS_I2C_IRQ && startup_done_r
            |=> serial_out_irq_strap_pin.oe == $past(irq_en)
            && serial_out_irq_strap_pin.o == $past(irq_level))
        else $error("interrupt role wrong in i2c");

    // nothing may fight the strap level while it is being read
    a_strap_undriven: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE1
        !startup_done_r && is_i2c(mode) |=> !serial_out_irq_strap_pin.oe)
        else $error("strap pin driven during start-up");

    // shared data line follows the engine outside 4-wire spi
    a_sdi_shared: assert property (@(posedge ref_clk) disable iff (!nrst) // RULE7
        mode != PMS_SPI4 |=> serial_in_or_bidir_line.oe == $past(bidir_oe))
        else $error("shared data line drive wrong");

endmodule

/* logic/pms_pkg.sv */
/*
 * package for the sensor pin role and address strap block: interface mode
 * encoding, the pin-direction carriers and the start-up timing counts.
 * assumes a single 20 MHz reference clock shared by every user of this package.
 */
package pms_pkg;

    // interface mode selected by the surrounding configuration logic
    typedef enum logic [2:0] {
        PMS_SPI3,       // 3-wire spi, no interrupt
        PMS_SPI3_IRQ,   // 3-wire spi with interrupt on the data-out pin
        PMS_SPI4,       // 4-wire spi
        PMS_I2C,        // i2c, strap only
        PMS_I2C_IRQ     // i2c with interrupt and strap
    } pms_mode_t;

    // three-signal view of one pad
    typedef struct packed {
        logic o;    // level driven toward the pad
        logic oe;   // high while the block drives the pad
        logic pu;   // internal pull-up enable
    } pms_pad_t;

    // clock period and start-up window length
    localparam int unsigned PMS_CLK_PERIOD_NS = 50;
    localparam int unsigned PMS_STARTUP_NS    = 1000;
    // start-up window is a least time, so round up
    localparam int unsigned PMS_STARTUP_CYC   =
        (PMS_STARTUP_NS + PMS_CLK_PERIOD_NS - 1) / PMS_CLK_PERIOD_NS;
    localparam int unsigned PMS_CNT_W         = 8;

    // reset values
    localparam logic        PMS_ADDR_LSB_RST  = 1'b1;
    localparam logic        PMS_PULLUP_RST    = 1'b1;

endpackage

/* verification/pms_host_model.sv */
/*
 * host-side model of the serial pads: resolves pad levels from device
 * and host drive. assumes a single ref_clk and the pms_pkg pad carriers.
 */
`timescale 1ns/1ps
module pms_host_model (
    input  wire logic               ref_clk,    // reference clock
    input  wire pms_pkg::pms_mode_t mode,       // interface mode
    input  wire pms_pkg::pms_pad_t  sdo_pad,    // device data-out drive
    input  wire pms_pkg::pms_pad_t  sdi_pad,    // device data-in drive
    input  wire logic               ext_pd,     // board pull-down on strap
    input  wire logic               host_sdi,   // host data level
    input  wire logic               host_cs_n,  // host chip select
    output logic                    sdo_lvl,    // data-out wire level
    output logic                    sdi_lvl,    // data-in wire level
    output logic                    cs_lvl      // chip select wire level
);
    import pms_pkg::*;
    logic flip_r = 1'b0; // floating wire pattern
    always @(posedge ref_clk) flip_r <= ~flip_r;
    // wire levels from all drivers
    always_comb begin
        if (sdo_pad.oe) sdo_lvl = sdo_pad.o;
        else if (ext_pd) sdo_lvl = 1'b0;
        else if (sdo_pad.pu) sdo_lvl = 1'b1;
        else sdo_lvl = flip_r; // undriven: changes every cycle
        sdi_lvl = sdi_pad.oe ? sdi_pad.o : host_sdi;
        // i2c: host leaves chip select open, only pull-up holds it
        cs_lvl = (mode == PMS_I2C || mode == PMS_I2C_IRQ) ? 1'b1 : host_cs_n;
    end
endmodule

/* verification/interface_pin_role_and_address_strap_tb_top.sv */
/*
 * self-checking bench for pms_pin_role: strap latch, pull-up control and
 * pin roles per mode. assumes the host model resolves pad levels.
 */
`timescale 1ns/1ps
module interface_pin_role_and_address_strap_tb_top;
    import pms_pkg::*;
    localparam int unsigned SC = 4; // shortened start-up
    logic ref_clk = 1'b0, nrst = 1'b0, irq_en = 1'b0, irq_level = 1'b0;
    logic spi_sdo_data = 1'b0, sdo_drive = 1'b0, bidir_o = 1'b0, bidir_oe = 1'b0;
    logic ext_pd = 1'b0, host_sdi = 1'b0, host_cs_n = 1'b1;
    logic sdo_lvl, sdi_lvl, cs_lvl, cs_pu, cs_r, sd_r, addr, done;
    pms_mode_t mode = PMS_I2C;
    pms_pad_t sdo_pad, sdi_pad;
    int n_fail = 0, num_checks = 0;
    always #25 ref_clk = ~ref_clk;
    pms_pin_role #(.STARTUP_CYC(SC)) pms_pin_role_i (.ref_clk(ref_clk), .nrst(nrst),
        .mode(mode), .irq_en(irq_en), .irq_level(irq_level), .spi_sdo_data(spi_sdo_data),
        .sdo_drive(sdo_drive), .bidir_o(bidir_o), .bidir_oe(bidir_oe),
        .serial_out_irq_strap_pin_i(sdo_lvl), .serial_in_or_bidir_line_i(sdi_lvl),
        .chip_select_n_i(cs_lvl), .serial_out_irq_strap_pin(sdo_pad),
        .serial_in_or_bidir_line(sdi_pad), .chip_select_n_pu(cs_pu),
        .chip_select_n_r(cs_r), .serial_data_r(sd_r), .addr_lsb_r(addr),
        .startup_done_r(done));
    pms_host_model pms_host_model_i (.ref_clk(ref_clk), .mode(mode), .sdo_pad(sdo_pad),
        .sdi_pad(sdi_pad), .ext_pd(ext_pd), .host_sdi(host_sdi), .host_cs_n(host_cs_n),
        .sdo_lvl(sdo_lvl), .sdi_lvl(sdi_lvl), .cs_lvl(cs_lvl));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic seen, input logic exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("ERROR %0t: %s seen %b expected %b", $time, what, seen, exp);
        end
    endtask
    task automatic cyc(input int n); // step n edges, land just after
        repeat (n) @(posedge ref_clk);
        #2;
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    function automatic logic is_i2c(input pms_mode_t m);
        return m == PMS_I2C || m == PMS_I2C_IRQ;
    endfunction
    function automatic logic exp_oe(input pms_mode_t m); // data-out drive by role
        case (m)
            PMS_SPI3_IRQ, PMS_I2C_IRQ: return irq_en;
            PMS_SPI4: return sdo_drive;
            default: return 1'b0;
        endcase
    endfunction
    // reset, start-up with a given strap, then late strap change
    task automatic boot(input logic pd);
        int k;
        nrst = 1'b0; mode = PMS_I2C; irq_en = 1'b0; ext_pd = pd;
        cyc(3);
        nrst = 1'b1;
        cyc(1);
        check(sdo_pad.pu, 1'b1, "strap pull-up in start-up");
        check(sdo_pad.oe, 1'b0, "strap not driven in start-up");
        for (k = 0; k < 20 && done !== 1'b1; k++) cyc(1);
        if (done !== 1'b1) begin
            check(1'b0, 1'b1, "start-up never ended");
            finish_test();
        end
        check(addr, ~pd, "address bit from strap");
        cyc(2);
        check(sdo_pad.pu, ~pd, "pull-up after start-up");
        ext_pd = ~pd;
        cyc(6);
        check(addr, ~pd, "address held after strap change");
        mode = PMS_I2C_IRQ; irq_en = 1'b1; ext_pd = pd;
        cyc(2);
        check(sdo_pad.pu, 1'b0, "pull-up off with interrupt");
        $display("test boot strap %b done", ~pd);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        int i;
        void'($urandom(32'h17f7bb50));
        boot(1'b1);
        boot(1'b0); // last boot leaves the strap sampled high
        for (i = 0; i < 60; i++) begin // random roles, corner modes first
            mode = pms_mode_t'(i < 5 ? i : $urandom_range(4));
            {irq_en, irq_level, spi_sdo_data, sdo_drive} = 4'($urandom);
            {bidir_o, bidir_oe, host_sdi, host_cs_n} = 4'($urandom);
            cyc(5);
            check(sdo_pad.oe, exp_oe(mode), "data-out drive");
            if (mode == PMS_SPI4 && sdo_drive) check(sdo_pad.o, spi_sdo_data, "spi data");
            if ((mode == PMS_SPI3_IRQ || mode == PMS_I2C_IRQ) && irq_en)
                check(sdo_pad.o, irq_level, "irq level");
            check(sdi_pad.oe, mode != PMS_SPI4 && bidir_oe, "data-in drive");
            if (sdi_pad.oe === 1'b1) check(sdi_pad.o, bidir_o, "data-in value");
            check(sd_r, sdi_lvl, "data-in to engines");
            check(cs_r, is_i2c(mode) ? 1'b1 : host_cs_n, "chip select");
            check(cs_pu, is_i2c(mode), "chip select pull-up");
            // strap was high: pull-up stays only in i2c without interrupt
            check(sdo_pad.pu, is_i2c(mode) && !irq_en, "strap pull-up");
            check(addr, 1'b1, "address held in random run");
            check(sdi_pad.pu, 1'b0, "data-in pull-up");
        end
        $display("test random roles done");
        finish_test();
    end
endmodule
